// *** rtl/gbd_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Decode lockout, clear, poll on and poll off regardless of addressing.
// - Go-local, selected clear and trigger only act once listen-addressed.
// - Bytes 20-3F are listen addresses; own address 20+addr makes listener.
// - Bytes 40-5F are talk addresses; 60-7F are secondary bytes.
// - Unlisten 3F ends listening, untalk 5F ends talking.
// - Bytes with attention released are data for an addressed listener.
// - Primary address resets to 15 until reconfigured.
module gbd_decoder (
  input wire logic CLK, // 20 MHz system clock
  input wire logic RST_N, // Async reset, active low
  input wire logic [7:0] DIO_IN, // Data lines, high is logic one
  input wire logic DAV_IN, // Source data valid, high true
  input wire logic ATN_IN, // Attention, high true
  output logic NRFD_OUT, // Not ready for data, high true
  output logic NDAC_OUT, // Not data accepted, high true
  input wire logic ADDR_LOAD, // Load new primary address
  input wire logic [4:0] ADDR_VAL, // New primary address
  output logic [4:0] ADDR_OUT, // Current primary address
  output logic LISTEN_OUT, // Listener state
  output logic TALK_OUT, // Talker state
  output logic LOCKOUT_OUT, // Local lockout latched
  output logic POLL_OUT, // Serial poll mode
  output logic DEV_CLEAR_OUT, // Clear pulse (universal or selected)
  output logic GO_LOCAL_OUT, // Go-to-local pulse
  output logic TRIGGER_OUT, // Trigger pulse
  output logic SECOND_OUT, // Secondary byte pulse
  output logic [4:0] SECOND_VAL, // Secondary byte low bits
  output logic DATA_VALID, // Data byte available
  output logic [7:0] DATA_OUT, // Data byte
  input wire logic DATA_READY // Consumer takes data byte
);
  // ==========================================================
  // Pin synchronisers
  logic [9:0] s1_r, s2_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= 10'h000;
      s2_r <= 10'h000;
    end else begin
      s1_r <= {ATN_IN, DAV_IN, DIO_IN};
      s2_r <= s1_r;
    end
  end
  wire logic atn = s2_r[9];
  wire logic dav = s2_r[8];
  wire logic [7:0] dio = s2_r[7:0];
  wire logic [6:0] cmd = s2_r[6:0];

  function automatic logic addr_hit(input logic [6:0] c,
      input logic [1:0] grp, input logic [4:0] a);
    addr_hit = (c[6:5] == grp) && (c[4:0] == a);
  endfunction : addr_hit

  // ==========================================================
  // Buffer between acceptor and consumer
  gbd_stream_if dstr ();
  logic bo_valid;
  logic [7:0] bo_data;
  logic take;
  gbd_buf2 u_buf (
    .clk(CLK),
    .rst_n(RST_N),
    .in_s(dstr.snk),
    .out_valid(bo_valid),
    .out_data(bo_data),
    .out_ready(take)
  );

  // ==========================================================
  // State
  gbd_pkg::gbd_ah_e ah_r, ah_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic lsn_r, lsn_nxt, tlk_r, tlk_nxt, llo_r, llo_nxt;
  logic spe_r, spe_nxt, clr_r, clr_nxt, gtl_r, gtl_nxt;
  logic trg_r, trg_nxt, sec_r, sec_nxt;
  logic [4:0] secv_r, secv_nxt;
  logic nrfd_r, nrfd_nxt, ndac_r, ndac_nxt;
  logic dv_r, dv_nxt;
  logic [7:0] dd_r, dd_nxt;
  logic push;

  // Data bytes are pushed only as the handshake accepts them
  assign dstr.valid = push;
  assign dstr.data = dio;
  // Head moves on when the output register is empty or being taken
  assign take = bo_valid && (!dv_r || DATA_READY);

  // Acceptor handshake and command decode
  always_comb begin
    ah_nxt = ah_r;
    addr_nxt = ADDR_LOAD ? ADDR_VAL : addr_r;
    lsn_nxt = lsn_r;
    tlk_nxt = tlk_r;
    llo_nxt = llo_r;
    spe_nxt = spe_r;
    clr_nxt = 1'b0;
    gtl_nxt = 1'b0;
    trg_nxt = 1'b0;
    sec_nxt = 1'b0;
    secv_nxt = secv_r;
    nrfd_nxt = nrfd_r;
    ndac_nxt = ndac_r;
    push = 1'b0;
    case (ah_r)
      gbd_pkg::AH_READY: begin
        // Not ready while buffer is full, so the source stalls
        nrfd_nxt = !dstr.ready;
        ndac_nxt = 1'b1;
        if (dav && !nrfd_r) begin
          nrfd_nxt = 1'b1;
          ah_nxt = gbd_pkg::AH_TAKE;
        end
      end
      gbd_pkg::AH_TAKE: begin
        ndac_nxt = 1'b0;
        ah_nxt = gbd_pkg::AH_WAIT;
        if (atn) begin
          case (cmd)
            gbd_pkg::CMD_LOCKOUT: llo_nxt = 1'b1;
            gbd_pkg::CMD_DEV_CLEAR: clr_nxt = 1'b1;
            gbd_pkg::CMD_POLL_ON: spe_nxt = 1'b1;
            gbd_pkg::CMD_POLL_OFF: spe_nxt = 1'b0;
            gbd_pkg::CMD_GO_LOCAL: gtl_nxt = lsn_r;
            gbd_pkg::CMD_SEL_CLEAR: clr_nxt = lsn_r;
            gbd_pkg::CMD_TRIGGER: trg_nxt = lsn_r;
            gbd_pkg::CMD_UNLISTEN: lsn_nxt = 1'b0;
            gbd_pkg::CMD_UNTALK: tlk_nxt = 1'b0;
            default: begin
              if (addr_hit(cmd, gbd_pkg::GRP_LISTEN, addr_r)) begin
                lsn_nxt = 1'b1;
              end
              // Another talker's address retires ours
              if (cmd[6:5] == gbd_pkg::GRP_TALK) begin
                tlk_nxt = addr_hit(cmd, gbd_pkg::GRP_TALK, addr_r);
              end
              if (cmd[6:5] == gbd_pkg::GRP_SECOND) begin
                sec_nxt = lsn_r || tlk_r;
                secv_nxt = cmd[4:0];
              end
            end
          endcase
        end else if (lsn_r) begin
          push = 1'b1;
        end
      end
      gbd_pkg::AH_WAIT: begin
        // Hold accepted until the source drops valid
        if (!dav) begin
          ndac_nxt = 1'b1;
          ah_nxt = gbd_pkg::AH_READY;
        end
      end
      default: ah_nxt = gbd_pkg::AH_READY;
    endcase
    // Output register; reloads in the cycle it empties, so no bubble
    dv_nxt = dv_r;
    dd_nxt = dd_r;
    if (dv_r && DATA_READY) begin
      dv_nxt = 1'b0;
    end
    if (take) begin
      dv_nxt = 1'b1;
      dd_nxt = bo_data;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ah_r <= gbd_pkg::AH_READY;
      addr_r <= gbd_pkg::ADDR_RESET;
      lsn_r <= 1'b0;
      tlk_r <= 1'b0;
      llo_r <= 1'b0;
      spe_r <= 1'b0;
      clr_r <= 1'b0;
      gtl_r <= 1'b0;
      trg_r <= 1'b0;
      sec_r <= 1'b0;
      secv_r <= 5'h00;
      nrfd_r <= 1'b1;
      ndac_r <= 1'b1;
      dv_r <= 1'b0;
      dd_r <= 8'h00;
    end else begin
      ah_r <= ah_nxt;
      addr_r <= addr_nxt;
      lsn_r <= lsn_nxt;
      tlk_r <= tlk_nxt;
      llo_r <= llo_nxt;
      spe_r <= spe_nxt;
      clr_r <= clr_nxt;
      gtl_r <= gtl_nxt;
      trg_r <= trg_nxt;
      sec_r <= sec_nxt;
      secv_r <= secv_nxt;
      nrfd_r <= nrfd_nxt;
      ndac_r <= ndac_nxt;
      dv_r <= dv_nxt;
      dd_r <= dd_nxt;
    end
  end

  // Every output straight from a register, no gating on the way out
  assign NRFD_OUT = nrfd_r;
  assign NDAC_OUT = ndac_r;
  assign ADDR_OUT = addr_r;
  assign LISTEN_OUT = lsn_r;
  assign TALK_OUT = tlk_r;
  assign LOCKOUT_OUT = llo_r;
  assign POLL_OUT = spe_r;
  assign DEV_CLEAR_OUT = clr_r;
  assign GO_LOCAL_OUT = gtl_r;
  assign TRIGGER_OUT = trg_r;
  assign SECOND_OUT = sec_r;
  assign SECOND_VAL = secv_r;
  assign DATA_VALID = dv_r;
  assign DATA_OUT = dd_r;
endmodule : gbd_decoder
`default_nettype wire

// *** rtl/gbd_pkg.sv ***
`default_nettype none
package gbd_pkg;
  // ==========================================================
  // Command codes on the data lines while attention is active
  localparam logic [6:0] CMD_GO_LOCAL = 7'h01;
  localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
  localparam logic [6:0] CMD_TRIGGER = 7'h08;
  localparam logic [6:0] CMD_LOCKOUT = 7'h11;
  localparam logic [6:0] CMD_DEV_CLEAR = 7'h14;
  localparam logic [6:0] CMD_POLL_ON = 7'h18;
  localparam logic [6:0] CMD_POLL_OFF = 7'h19;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3F;
  localparam logic [6:0] CMD_UNTALK = 7'h5F;
  // ==========================================================
  // Group bases, top two bits of the seven-bit command
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECOND = 2'h3;
  localparam logic [4:0] ADDR_RESET = 5'h0F;
  // ==========================================================
  // Acceptor handshake states
  typedef enum logic [1:0] {
    AH_READY = 2'b00,
    AH_TAKE = 2'b01,
    AH_WAIT = 2'b10
  } gbd_ah_e;
endpackage : gbd_pkg
`default_nettype wire

// *** rtl/gbd_stream_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Valid/ready byte stream between decoder and its buffer
interface gbd_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : gbd_stream_if
`default_nettype wire

// *** rtl/gbd_buf2.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Two-entry skid buffer; a stalled receiver loses no byte
module gbd_buf2 (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  gbd_stream_if.snk in_s, // Filling side
  output logic out_valid, // Word available
  output logic [7:0] out_data, // Oldest word
  input wire logic out_ready // Drain side accepts
);
  logic [7:0] mem_r [2];
  logic [7:0] mem_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic push, pop;

  // Pointers and count
  always_comb begin
    push = in_s.valid && (cnt_r != 2'd2);
    pop = out_ready && (cnt_r != 2'd0);
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wr_r] = in_s.data;
    end
    wr_nxt = push ? ~wr_r : wr_r;
    rd_nxt = pop ? ~rd_r : rd_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end

  // Full and empty are honest; ready drops only when full
  assign in_s.ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rd_r];
endmodule : gbd_buf2
`default_nettype wire

// *** verif/gbd_decoder_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the command decoder
module gbd_chk (
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic DAV_IN, // Source valid
  input wire logic NRFD_OUT, // Not ready
  input wire logic NDAC_OUT, // Not accepted
  input wire logic ADDR_LOAD, // Load
  input wire logic [4:0] ADDR_VAL, // New address
  input wire logic [4:0] ADDR_OUT, // Address
  input wire logic LISTEN_OUT, // Listener
  input wire logic TALK_OUT, // Talker
  input wire logic TRIGGER_OUT, // Trigger
  input wire logic DEV_CLEAR_OUT, // Clear
  input wire logic DATA_VALID, // Word ready
  input wire logic [7:0] DATA_OUT, // Word
  input wire logic DATA_READY // Word taken
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Handshake, decode moments, address register and the output buffer
  AST_NDAC_HOLD: assert property (
    !NDAC_OUT && DAV_IN |=> !NDAC_OUT) else $error("accept dropped early");
  AST_ACCEPT_CAUSE: assert property (
    $fell(NDAC_OUT) |-> NRFD_OUT && $past(DAV_IN, 2)) else $error("bad accept");
  AST_PULSE_ONE: assert property (
    TRIGGER_OUT || DEV_CLEAR_OUT |-> $fell(NDAC_OUT) ##1
    !(TRIGGER_OUT || DEV_CLEAR_OUT)) else $error("pulse misplaced");
  AST_TRIG_LISTEN: assert property (
    TRIGGER_OUT |-> LISTEN_OUT) else $error("trigger while unaddressed");
  AST_ROLE_AT_ACCEPT: assert property (
    $changed({LISTEN_OUT, TALK_OUT}) |-> $fell(NDAC_OUT))
    else $error("role changed off a byte");
  AST_ADDR_LOAD: assert property (
    ADDR_LOAD |=> ADDR_OUT == $past(ADDR_VAL)) else $error("address not loaded");
  AST_ADDR_KEEP: assert property (
    !ADDR_LOAD |=> $stable(ADDR_OUT)) else $error("address drifted");
  AST_DATA_HOLD: assert property (
    DATA_VALID && !DATA_READY |=> DATA_VALID && $stable(DATA_OUT))
    else $error("stalled word lost");
  // Main traffic seen at least once
  cover property (TRIGGER_OUT);
  cover property ($rose(TALK_OUT));
  cover property (DATA_VALID && !DATA_READY ##1 DATA_READY);
endmodule : gbd_chk
bind gbd_decoder gbd_chk u_chk (.CLK(CLK), .RST_N(RST_N), .DAV_IN(DAV_IN),
  .NRFD_OUT(NRFD_OUT), .NDAC_OUT(NDAC_OUT), .ADDR_LOAD(ADDR_LOAD),
  .ADDR_VAL(ADDR_VAL), .ADDR_OUT(ADDR_OUT), .LISTEN_OUT(LISTEN_OUT),
  .TALK_OUT(TALK_OUT), .TRIGGER_OUT(TRIGGER_OUT),
  .DEV_CLEAR_OUT(DEV_CLEAR_OUT), .DATA_VALID(DATA_VALID),
  .DATA_OUT(DATA_OUT), .DATA_READY(DATA_READY));
`default_nettype wire

// *** verif/gbd_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bus controller: one byte per three-wire handshake
module gbd_ctrl_model (
  input wire logic CLK, // Clock
  input wire logic NRFD, // Acceptor not ready
  input wire logic NDAC, // Acceptor not accepted
  output logic [7:0] DIO, // Data lines
  output logic DAV, // Data valid
  output logic ATN // Attention
);
  initial begin
    DIO = 8'hFF;
    DAV = 1'b0;
    ATN = 1'b0;
  end
  // Waits are bounded so a stuck acceptor returns ok low
  task automatic send(input logic [7:0] b, input logic atn, output logic ok);
    int n;
    @(negedge CLK);
    ATN = atn;
    DIO = b;
    @(negedge CLK);
    for (n = 0; n < 200 && NRFD; n++) @(negedge CLK);
    ok = !NRFD;
    DAV = 1'b1;
    for (n = 0; n < 20 && NDAC; n++) @(negedge CLK);
    ok = ok && !NDAC;
    DAV = 1'b0;
    for (n = 0; n < 20 && !NDAC; n++) @(negedge CLK);
    ok = ok && NDAC;
    DIO = ~b; // Released lines no longer show the byte
  endtask : send
endmodule : gbd_ctrl_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench for the bus command decoder
module tb;
  logic clk, rst_n, addr_load, data_ready, ok, dav, atn, nrfd, ndac;
  logic listen, talk, lockout, poll, clr_p, gtl_p, trg_p, sec_p, data_valid;
  logic [4:0] addr_val, addr_out, second_val;
  logic [7:0] dio, data_out, n_clr, n_gtl, n_trg, n_sec;
  logic [7:0] got[$];
  int err_total, samples_checked;
  gbd_ctrl_model ctl (.CLK(clk), .NRFD(nrfd), .NDAC(ndac), .DIO(dio),
    .DAV(dav), .ATN(atn));
  gbd_decoder uut (.CLK(clk), .RST_N(rst_n), .DIO_IN(dio), .DAV_IN(dav),
    .ATN_IN(atn), .NRFD_OUT(nrfd), .NDAC_OUT(ndac), .ADDR_LOAD(addr_load),
    .ADDR_VAL(addr_val), .ADDR_OUT(addr_out), .LISTEN_OUT(listen),
    .TALK_OUT(talk), .LOCKOUT_OUT(lockout), .POLL_OUT(poll),
    .DEV_CLEAR_OUT(clr_p), .GO_LOCAL_OUT(gtl_p), .TRIGGER_OUT(trg_p),
    .SECOND_OUT(sec_p), .SECOND_VAL(second_val), .DATA_VALID(data_valid),
    .DATA_OUT(data_out), .DATA_READY(data_ready));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulses last one cycle, so count them at every edge
  always @(posedge clk) begin
    n_clr <= n_clr + {7'h0, clr_p};
    n_gtl <= n_gtl + {7'h0, gtl_p};
    n_trg <= n_trg + {7'h0, trg_p};
    n_sec <= n_sec + {7'h0, sec_p};
  end
  task automatic zero;
    {n_clr, n_gtl, n_trg, n_sec} = 32'h0;
  endtask : zero
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic tx(input logic [7:0] b, input logic a);
    ctl.send(b, a, ok);
    if (!ok) begin
      err_total++;
      wrap_up();
    end
    repeat (2) @(negedge clk);
  endtask : tx
  // Command bytes under attention, first byte in the top lane
  task automatic run(input logic [31:0] w, input int k);
    for (int i = k - 1; i >= 0; i--) tx(w[8*i+:8], 1'b1);
  endtask : run
  task automatic t_universal;
    zero();
    run(32'h3F111418, 4);
    check({6'h0, lockout, poll}, 8'h03);
    check(n_clr, 8'h01);
    run(32'h19, 1);
    check({6'h0, lockout, poll}, 8'h02);
  endtask : t_universal
  task automatic t_addressed;
    zero();
    run(32'h3F010408, 4);
    check(n_gtl + n_clr + n_trg, 8'h00);
    run(32'h2F010408, 4);
    check({n_gtl[1:0], n_clr[1:0], n_trg[1:0], 1'b0, listen}, 8'h55);
  endtask : t_addressed
  task automatic t_talk;
    zero();
    run(32'h4F65, 2);
    check({talk, listen, n_sec[0], second_val}, 8'hE5);
    run(32'h5F3F, 2);
    check({6'h0, talk, listen}, 8'h00);
  endtask : t_talk
  task automatic t_addr;
    addr_val = 5'h03;
    addr_load = 1'b1;
    @(negedge clk);
    addr_load = 1'b0;
    check({3'h0, addr_out}, 8'h03);
    run(32'h2F, 1);
    check({7'h0, listen}, 8'h00);
    run(32'h23, 1);
    check({7'h0, listen}, 8'h01);
    addr_val = 5'h0F;
    addr_load = 1'b1;
    @(negedge clk);
    addr_load = 1'b0;
  endtask : t_addr
  // Mid-run reset drops roles and restores the default address
  task automatic t_reset;
    addr_val = 5'h07;
    addr_load = 1'b1;
    @(negedge clk);
    addr_load = 1'b0;
    check({3'h0, addr_out}, 8'h07);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check({2'h0, listen, addr_out}, 8'h0F);
  endtask : t_reset
  // Receiver stalls until the buffer refuses, then drains it
  task automatic t_data;
    run(32'h3F2F, 2);
    data_ready = 1'b0;
    fork
      begin
        tx(8'h52, 1'b0);
        tx(8'h30, 1'b0);
        tx(8'h58, 1'b0);
        tx(8'h0D, 1'b0);
      end
      begin
        repeat (60) @(negedge clk);
        data_ready = 1'b1;
        for (int i = 0; i < 400 && got.size() < 4; i++) begin
          if (data_valid) got.push_back(data_out);
          @(negedge clk);
        end
      end
    join
    // Drain loop ran out of time: count it and stop
    if (got.size() < 4) begin
      err_total++;
      wrap_up();
    end
    check(got[0], 8'h52);
    check(got[1], 8'h30);
    check(got[2], 8'h58);
    check(got[3], 8'h0D);
    run(32'h3F, 1);
    tx(8'h41, 1'b0);
    check({7'h0, data_valid}, 8'h00);
  endtask : t_data
  initial begin
    rst_n = 1'b0;
    addr_load = 1'b0;
    addr_val = 5'h0F;
    data_ready = 1'b1;
    err_total = 0;
    samples_checked = 0;
    zero();
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check({3'h0, addr_out}, 8'h0F);
    t_universal();
    t_addressed();
    t_talk();
    t_addr();
    t_reset();
    t_data();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
